// ==== verilog/tpw_map.vh ====
// Purpose: register offsets, field positions and reset values of the
//   three-channel pwm block
// Assumes: byte-wide registers, one per aligned 32-bit wishbone word
// Notes: printed offsets are not all multiples of four, so each offset is
//   an index and the byte address is four times the index
`ifndef TPW_MAP_VH
`define TPW_MAP_VH

`define TPW_IDX_CH0_PERIOD 8'h9A
`define TPW_IDX_CH0_DUTY_HIGH 8'h9B
`define TPW_IDX_CH1_PERIOD 8'h9C
`define TPW_IDX_CH1_DUTY_HIGH 8'h9D
`define TPW_IDX_CH2_PERIOD 8'h9E
`define TPW_IDX_CH2_DUTY_HIGH 8'h9F
`define TPW_IDX_CH01_CTRL 8'hA1
`define TPW_IDX_PIN_OE 8'hA6
`define TPW_IDX_CH2_CTRL 8'hA7
`define TPW_IDX_MISC 8'hF8
`define TPW_IDX_OD_MODE 8'hB0

`define TPW_RST_PERIOD 8'hFF
`define TPW_RST_DUTY_HIGH 8'h80
`define TPW_RST_CH01_CTRL 8'h88
`define TPW_RST_PIN_OE 8'h00
`define TPW_RST_CH2_CTRL 8'h08
`define TPW_RST_MISC 8'h00
`define TPW_RST_OD_MODE 8'h00

`define TPW_MASK_PIN_OE 8'hC0
`define TPW_MASK_CH2_CTRL 8'h1F
`define TPW_MASK_OD_MODE 8'h07

`define TPW_BIT_CH1_OE 7
`define TPW_BIT_CH0_OE 6
`define TPW_BIT_CH2_OE 4
`define TPW_BIT_CH0_CLEAR 3

`define TPW_CKS_DIV4 2'h0
`define TPW_CKS_DIV2 2'h1
`define TPW_CKS_DIV1 2'h2
`define TPW_CKS_FRC 2'h3

`endif

// ==== verilog/tpw_channel.v ====
// Purpose: one pwm channel with base counter and spread low duty bits
// Assumes: tick is a one-cycle enable at the channel's pwm clock rate
// Notes: hold forces the channel to its cleared state
`timescale 1ns/10ps
module tpw_channel (
  ref_clk,
  srst,
  enable,
  hold,
  tick,
  period,
  duty,
  pwm_out
);
  input wire ref_clk;
  input wire srst;
  input wire enable;
  input wire hold;
  input wire tick;
  input wire [7:0] period;
  input wire [9:0] duty;
  output reg pwm_out;

  reg [7:0] base_cnt_reg;
  reg [1:0] frac_cnt_reg;
  reg delay_pend_reg;
  wire rollover;
  wire use_delay;
  wire [7:0] cnt_inc;

  assign rollover = (base_cnt_reg >= period);
  assign cnt_inc = base_cnt_reg + 8'h01;
  // n of every four base periods take the delayed rising edge
  assign use_delay = (frac_cnt_reg < duty[1:0]);

  always @(posedge ref_clk) begin
    if (srst || !enable || hold) begin
      base_cnt_reg <= 8'h00;
      frac_cnt_reg <= 2'h0;
      delay_pend_reg <= 1'b0;
      pwm_out <= 1'b0;
    end else if (tick) begin
      delay_pend_reg <= 1'b0;
      if (rollover) begin
        base_cnt_reg <= 8'h00;
        frac_cnt_reg <= frac_cnt_reg + 2'h1;
        if (duty[9:2] == 8'h00) begin
          pwm_out <= 1'b0;
        end else if (use_delay) begin
          delay_pend_reg <= 1'b1;
        end else begin
          pwm_out <= 1'b1;
        end
      end else begin
        base_cnt_reg <= cnt_inc;
        // low in the same cycle the counter reaches the match value
        if (cnt_inc == duty[9:2]) begin
          pwm_out <= 1'b0;
        end else if (delay_pend_reg) begin
          pwm_out <= 1'b1;
        end
      end
    end
  end
endmodule

// ==== verilog/tpw_top.v ====
// Purpose: three-channel pwm with spread low duty bits, wishbone registers
// Assumes: classic wishbone slave, 32-bit data, byte registers in low lane
// Notes: output pins carry data and output enable for open drain or cmos
`timescale 1ns/10ps
`include "tpw_map.vh"
module tpw_top (
  ref_clk,
  srst,
  frc_clk_in,
  wb_cyc_i,
  wb_stb_i,
  wb_we_i,
  wb_adr_i,
  wb_sel_i,
  wb_dat_i,
  wb_dat_o,
  wb_ack_o,
  pwm_pin_o,
  pwm_pin_oe
);
  input wire ref_clk;
  input wire srst;
  input wire frc_clk_in;
  input wire wb_cyc_i;
  input wire wb_stb_i;
  input wire wb_we_i;
  input wire [9:0] wb_adr_i;
  input wire [3:0] wb_sel_i;
  input wire [31:0] wb_dat_i;
  output reg [31:0] wb_dat_o;
  output reg wb_ack_o;
  output reg [2:0] pwm_pin_o;
  output reg [2:0] pwm_pin_oe;

  reg [7:0] ch0_period_value;
  reg [7:0] ch1_period_value;
  reg [7:0] ch2_period_value;
  reg [7:0] ch0_duty_upper_bits;
  reg [7:0] ch1_duty_upper_bits;
  reg [7:0] ch2_duty_upper_bits;
  reg [7:0] ch0_ch1_control;
  reg [7:0] pin_output_enables;
  reg [7:0] ch2_control_reg;
  reg [7:0] misc_control_strobes;
  reg [7:0] od_mode_reg;
  reg [1:0] div_cnt_reg;
  reg frc_meta_reg;
  reg frc_sync_reg;
  reg frc_prev_reg;
  reg [7:0] rd_byte;
  wire [7:0] idx;
  wire wr_en;
  wire tick_div2;
  wire tick_div4;
  wire tick_frc;
  wire [2:0] ch_tick;
  wire [2:0] ch_wave;
  wire [2:0] ch_en;
  wire [2:0] pin_drv;
  wire ch0_clear_hold;

  // pick the per-channel pwm clock enable
  function sel_tick;
    input [1:0] cks;
    input t4;
    input t2;
    input tf;
    begin
      case (cks)
        `TPW_CKS_DIV4: sel_tick = t4;
        `TPW_CKS_DIV2: sel_tick = t2;
        `TPW_CKS_DIV1: sel_tick = 1'b1;
        default: sel_tick = tf;
      endcase
    end
  endfunction

  assign idx = wb_adr_i[9:2];
  // write lands at the edge where the master samples ack
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];

  // dividers and fast rc edge detect
  always @(posedge ref_clk) begin
    if (srst) begin
      div_cnt_reg <= 2'h0;
      frc_meta_reg <= 1'b0;
      frc_sync_reg <= 1'b0;
      frc_prev_reg <= 1'b0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 2'h1;
      frc_meta_reg <= frc_clk_in;
      frc_sync_reg <= frc_meta_reg;
      frc_prev_reg <= frc_sync_reg;
    end
  end

  assign tick_div2 = div_cnt_reg[0];
  assign tick_div4 = (div_cnt_reg == 2'h3);
  assign tick_frc = frc_sync_reg && !frc_prev_reg;

  assign ch_tick[0] = sel_tick(ch0_ch1_control[3:2], tick_div4, tick_div2,
                               tick_frc);
  assign ch_tick[1] = sel_tick(ch0_ch1_control[7:6], tick_div4, tick_div2,
                               tick_frc);
  assign ch_tick[2] = sel_tick(ch2_control_reg[3:2], tick_div4, tick_div2,
                               tick_frc);

  assign ch_en[0] = pin_output_enables[`TPW_BIT_CH0_OE];
  assign ch_en[1] = pin_output_enables[`TPW_BIT_CH1_OE];
  assign ch_en[2] = ch2_control_reg[`TPW_BIT_CH2_OE];
  assign ch0_clear_hold = misc_control_strobes[`TPW_BIT_CH0_CLEAR];

  // three identical channels; only channel 0 sees the clear
  tpw_channel u_ch0 (
    .ref_clk(ref_clk),
    .srst(srst),
    .enable(ch_en[0]),
    .hold(ch0_clear_hold),
    .tick(ch_tick[0]),
    .period(ch0_period_value),
    .duty({ch0_duty_upper_bits, ch0_ch1_control[1:0]}),
    .pwm_out(ch_wave[0])
  );

  tpw_channel u_ch1 (
    .ref_clk(ref_clk),
    .srst(srst),
    .enable(ch_en[1]),
    .hold(1'b0),
    .tick(ch_tick[1]),
    .period(ch1_period_value),
    .duty({ch1_duty_upper_bits, ch0_ch1_control[5:4]}),
    .pwm_out(ch_wave[1])
  );

  tpw_channel u_ch2 (
    .ref_clk(ref_clk),
    .srst(srst),
    .enable(ch_en[2]),
    .hold(1'b0),
    .tick(ch_tick[2]),
    .period(ch2_period_value),
    .duty({ch2_duty_upper_bits, ch2_control_reg[1:0]}),
    .pwm_out(ch_wave[2])
  );

  assign pin_drv = ch_wave;

  // register writes
  always @(posedge ref_clk) begin
    if (srst) begin
      ch0_period_value <= `TPW_RST_PERIOD;
      ch1_period_value <= `TPW_RST_PERIOD;
      ch2_period_value <= `TPW_RST_PERIOD;
      ch0_duty_upper_bits <= `TPW_RST_DUTY_HIGH;
      ch1_duty_upper_bits <= `TPW_RST_DUTY_HIGH;
      ch2_duty_upper_bits <= `TPW_RST_DUTY_HIGH;
      ch0_ch1_control <= `TPW_RST_CH01_CTRL;
      pin_output_enables <= `TPW_RST_PIN_OE;
      ch2_control_reg <= `TPW_RST_CH2_CTRL;
      misc_control_strobes <= `TPW_RST_MISC;
      od_mode_reg <= `TPW_RST_OD_MODE;
    end else if (wr_en) begin
      if (idx == `TPW_IDX_CH0_PERIOD) begin
        ch0_period_value <= wb_dat_i[7:0];
      end else if (idx == `TPW_IDX_CH0_DUTY_HIGH) begin
        ch0_duty_upper_bits <= wb_dat_i[7:0];
      end else if (idx == `TPW_IDX_CH1_PERIOD) begin
        ch1_period_value <= wb_dat_i[7:0];
      end else if (idx == `TPW_IDX_CH1_DUTY_HIGH) begin
        ch1_duty_upper_bits <= wb_dat_i[7:0];
      end else if (idx == `TPW_IDX_CH2_PERIOD) begin
        ch2_period_value <= wb_dat_i[7:0];
      end else if (idx == `TPW_IDX_CH2_DUTY_HIGH) begin
        ch2_duty_upper_bits <= wb_dat_i[7:0];
      end else if (idx == `TPW_IDX_CH01_CTRL) begin
        ch0_ch1_control <= wb_dat_i[7:0];
      end else if (idx == `TPW_IDX_PIN_OE) begin
        pin_output_enables <= wb_dat_i[7:0] & `TPW_MASK_PIN_OE;
      end else if (idx == `TPW_IDX_CH2_CTRL) begin
        ch2_control_reg <= wb_dat_i[7:0] & `TPW_MASK_CH2_CTRL;
      end else if (idx == `TPW_IDX_MISC) begin
        misc_control_strobes <= wb_dat_i[7:0];
      end else if (idx == `TPW_IDX_OD_MODE) begin
        od_mode_reg <= wb_dat_i[7:0] & `TPW_MASK_OD_MODE;
      end
    end
  end

  // read mux; unmapped words read as zero
  always @* begin
    rd_byte = 8'h00;
    if (idx == `TPW_IDX_CH0_PERIOD) begin
      rd_byte = ch0_period_value;
    end else if (idx == `TPW_IDX_CH0_DUTY_HIGH) begin
      rd_byte = ch0_duty_upper_bits;
    end else if (idx == `TPW_IDX_CH1_PERIOD) begin
      rd_byte = ch1_period_value;
    end else if (idx == `TPW_IDX_CH1_DUTY_HIGH) begin
      rd_byte = ch1_duty_upper_bits;
    end else if (idx == `TPW_IDX_CH2_PERIOD) begin
      rd_byte = ch2_period_value;
    end else if (idx == `TPW_IDX_CH2_DUTY_HIGH) begin
      rd_byte = ch2_duty_upper_bits;
    end else if (idx == `TPW_IDX_CH01_CTRL) begin
      rd_byte = ch0_ch1_control;
    end else if (idx == `TPW_IDX_PIN_OE) begin
      rd_byte = pin_output_enables;
    end else if (idx == `TPW_IDX_CH2_CTRL) begin
      rd_byte = ch2_control_reg;
    end else if (idx == `TPW_IDX_MISC) begin
      rd_byte = misc_control_strobes;
    end else if (idx == `TPW_IDX_OD_MODE) begin
      rd_byte = {5'h00, ch_wave};
    end
  end

  // one-wait-state wishbone answer
  always @(posedge ref_clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) ?
                  {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  // pin drive: open drain pulls low only, push-pull drives both levels
  always @(posedge ref_clk) begin
    if (srst) begin
      pwm_pin_o <= 3'h0;
      pwm_pin_oe <= 3'h0;
    end else begin
      pwm_pin_o <= pin_drv & ~od_mode_reg[2:0];
      pwm_pin_oe <= ch_en & (~od_mode_reg[2:0] | ~pin_drv);
    end
  end
endmodule

// ==== sim/tpw_checker.sv ====
// Purpose: port checks for tpw_top
// Assumes: one clock domain, srst sync active high
// Notes: enable and drive-mode bits are shadowed from bus writes
`timescale 1ns/10ps
module tpw_checker (
  input wire ref_clk,
  input wire srst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [9:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [2:0] pwm_pin_o,
  input wire [2:0] pwm_pin_oe
);
  reg [6:0] sh_reg, s1_reg, s2_reg;
  wire wr = wb_ack_o & wb_we_i & wb_sel_i[0];
  wire [7:0] idx = wb_adr_i[9:2];
  wire st = (sh_reg == s1_reg) && (s1_reg == s2_reg);
  wire [2:0] en = sh_reg[3:1];
  wire [2:0] on = en & {2'h3, ~sh_reg[0]};
  wire [2:0] od = sh_reg[6:4];
  always @(posedge ref_clk) begin
    if (srst) begin
      sh_reg <= 7'h00;
      s1_reg <= 7'h00;
      s2_reg <= 7'h00;
    end else begin
      s1_reg <= sh_reg;
      s2_reg <= s1_reg;
      if (wr && idx == 8'hA6) sh_reg[2:1] <= wb_dat_i[7:6];
      if (wr && idx == 8'hA7) sh_reg[3] <= wb_dat_i[4];
      if (wr && idx == 8'hF8) sh_reg[0] <= wb_dat_i[3];
      if (wr && idx == 8'hB0) sh_reg[6:4] <= wb_dat_i[2:0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  a_ack_after_req: assert property (s_req |=> wb_ack_o)
    else $error("request not acked");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i))
    else $error("ack without request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_dat_upper: assert property (wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_reset_quiet: assert property ($fell(srst) |-> !(|pwm_pin_oe))
    else $error("pin driven after reset");
  a_off_quiet: assert property (st |->
    ((~en & pwm_pin_oe) | (~on & pwm_pin_o)) == 3'h0)
    else $error("stopped channel active");
  a_push_drive: assert property (st |-> (en & ~od & ~pwm_pin_oe) == 3'h0)
    else $error("push-pull pin not driven");
  a_od_low: assert property (st |-> (od & pwm_pin_o) == 3'h0)
    else $error("open-drain pin drives high");
endmodule
bind tpw_top tpw_checker i_tpw_checker (.ref_clk(ref_clk), .srst(srst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pwm_pin_o(pwm_pin_o),
  .pwm_pin_oe(pwm_pin_oe));

// ==== sim/tpw_load.sv ====
// Purpose: pulled-up integrating load on the three pwm pins
// Assumes: an undriven pin floats high through its pull-up
// Notes: hi_cnt holds 12-bit high-sample counts per pin since clr
`timescale 1ns/10ps
module tpw_load (
  input wire ref_clk,
  input wire clr,
  input wire [2:0] pin_o,
  input wire [2:0] pin_oe,
  output reg [35:0] hi_cnt
);
  wire [2:0] lvl = (pin_oe & pin_o) | ~pin_oe;
  integer k;
  always @(posedge ref_clk) begin
    for (k = 0; k < 3; k = k + 1) begin
      hi_cnt[12*k +: 12] <= clr ? 12'h000 :
        hi_cnt[12*k +: 12] + {11'h000, lvl[k]};
    end
  end
endmodule

// ==== sim/tpw_tb_top.sv ====
// Purpose: self-checking bench for tpw_top
// Assumes: 250 MHz ref_clk, fast rc clock at a tenth of it
// Notes: duty is the count of high ref_clk cycles over four base periods
`timescale 1ns/10ps
module tpw_tb_top;
  typedef struct packed {
    logic [1:0] ch;
    logic [1:0] cks;
    logic od;
    logic [7:0] prd;
    logic [7:0] dh;
    logic [1:0] dl;
    logic [11:0] res;
  } tpw_row_t;
  tpw_row_t rows [6] = '{
    '{2'h0, 2'h2, 1'h0, 8'h07, 8'h03, 2'h0, 12'h00C},
    '{2'h1, 2'h1, 1'h0, 8'h07, 8'h05, 2'h3, 12'h022},
    '{2'h2, 2'h0, 1'h1, 8'h03, 8'h02, 2'h1, 12'h01C},
    '{2'h0, 2'h3, 1'h0, 8'h04, 8'h02, 2'h2, 12'h03C},
    '{2'h2, 2'h2, 1'h0, 8'h09, 8'h00, 2'h3, 12'h000},
    '{2'h1, 2'h2, 1'h1, 8'hFF, 8'hFF, 2'h1, 12'h3FB}};
  logic [23:0] reg_tab [11] = '{24'h9AFFFF, 24'h9B80FF, 24'h9CFFFF,
    24'h9D80FF, 24'h9EFFFF, 24'h9F80FF, 24'hA188FF, 24'hA600C0,
    24'hA7081F, 24'hF800FF, 24'h800000};
  int dv [4] = '{4, 2, 1, 10};
  logic ref_clk, srst, cyc, stb, we, clr, ack;
  logic fast_rc_oscillator_clock = 1'b0;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_i, dat_o;
  logic [2:0] pin_o, pin_oe;
  logic [35:0] hi;
  logic [7:0] q;
  int fail_count, n_compared, cycles, fdiv;
  tpw_row_t r;
  tpw_top i_tpw_top (.ref_clk(ref_clk), .srst(srst), .frc_clk_in(fast_rc_oscillator_clock),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .pwm_pin_o(pin_o), .pwm_pin_oe(pin_oe));
  tpw_load i_tpw_load (.ref_clk(ref_clk), .clr(clr), .pin_o(pin_o),
    .pin_oe(pin_oe), .hi_cnt(hi));
  task automatic chk(input string nm, input logic [11:0] got, want);
    n_compared++;
    if (got !== want) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, want, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] ix, d,
      input logic [3:0] s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'h0};
    sel <= s;
    dat_i <= {24'h0, d};
    do begin
      @(posedge ref_clk);
    end while (ack !== 1'b1);
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic measure(input int w);
    repeat (2 * w) @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    repeat (w + 1) @(posedge ref_clk);
  endtask
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    fdiv <= (fdiv == 4) ? 0 : fdiv + 1;
    if (fdiv == 4) fast_rc_oscillator_clock <= ~fast_rc_oscillator_clock;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end
  initial begin
    {srst, cyc, stb, we, clr} = 5'h10;
    adr = 10'h000;
    sel = 4'h0;
    dat_i = 32'h0;
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    foreach (rows[i]) begin
      r = rows[i];
      bus(1'b1, 8'h9A + {5'h0, r.ch, 1'b0}, r.prd, 4'h1);
      bus(1'b1, 8'h9B + {5'h0, r.ch, 1'b0}, r.dh, 4'h1);
      bus(1'b1, 8'hA1, r.ch == 2'h0 ? {4'h0, r.cks, r.dl} :
        r.ch == 2'h1 ? {r.cks, r.dl, 4'h0} : 8'h00, 4'h1);
      bus(1'b1, 8'hB0, {5'h0, 3'h1 << r.ch} & {8{r.od}}, 4'h1);
      bus(1'b1, 8'hA7, r.ch == 2'h2 ? {4'h1, r.cks, r.dl} : 8'h00, 4'h1);
      bus(1'b1, 8'hA6, {r.ch == 2'h1, r.ch == 2'h0, 6'h00}, 4'h1);
      measure(4 * (r.prd + 1) * dv[r.cks]);
      chk("duty", hi[12*r.ch +: 12], r.res);
      $display("row %0d done", i);
    end
    bus(1'b1, 8'h9A, 8'h07, 4'h1);
    bus(1'b1, 8'h9B, 8'h03, 4'h1);
    bus(1'b1, 8'hA1, 8'h08, 4'h1);
    bus(1'b1, 8'hB0, 8'h00, 4'h1);
    bus(1'b1, 8'hA6, 8'h40, 4'h1);
    bus(1'b1, 8'hF8, 8'h08, 4'h1);
    measure(32);
    chk("held", hi[11:0], 12'h000);
    chk("idle pin", hi[23:12], 12'h020);
    bus(1'b1, 8'hF8, 8'h00, 4'h1);
    measure(32);
    chk("released", hi[11:0], 12'h00C);
    $display("clear hold done");
    srst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    foreach (reg_tab[i]) begin
      bus(1'b1, reg_tab[i][23:16], 8'h12, 4'hE);
      bus(1'b0, reg_tab[i][23:16], 8'h00, 4'h1);
      chk("reset", {4'h0, q}, {4'h0, reg_tab[i][15:8]});
      bus(1'b1, reg_tab[i][23:16], 8'hFF, 4'h1);
      bus(1'b0, reg_tab[i][23:16], 8'h00, 4'h1);
      chk("access", {4'h0, q}, {4'h0, reg_tab[i][7:0]});
    end
    $display("register checks done");
    conclude();
  end
endmodule
